/* File: cfg_bank_params.svh */
// constants of the converter configuration command bank
`ifndef CFG_BANK_PARAMS_SVH
`define CFG_BANK_PARAMS_SVH

// ****************************************
// command codes
// ****************************************
`define CMD_MONITOR_SCALE   8'h2A
`define CMD_DUTY_CEILING    8'h32
`define CMD_SWITCH_RATE     8'h33
`define CMD_INPUT_START     8'h35
`define CMD_INPUT_STOP      8'h36
`define CMD_PHASE_SPREAD    8'h37
`define CMD_CURRENT_OFFSET  8'h39
`define CMD_OV_TRIP_LEVEL   8'h40
`define CMD_OV_TRIP_ACTION  8'h41

// ****************************************
// storage indices
// ****************************************
`define NUM_REGS            9
`define IDX_MONITOR_SCALE   4'h0
`define IDX_DUTY_CEILING    4'h1
`define IDX_SWITCH_RATE     4'h2
`define IDX_INPUT_START     4'h3
`define IDX_INPUT_STOP      4'h4
`define IDX_PHASE_SPREAD    4'h5
`define IDX_CURRENT_OFFSET  4'h6
`define IDX_OV_TRIP_LEVEL   4'h7
`define IDX_OV_TRIP_ACTION  4'h8
`define IDX_NONE            4'hF

// ****************************************
// field positions and reset values
// ****************************************
`define SPREAD_USED_MASK    16'h0FFF
`define CFG_RESET_WORD      16'h0000
`define RESP_IGNORE         2'h0
`define RESP_DELAY_RETRY    2'h1
`define RESP_DISABLE_RETRY  2'h2
`define RESP_HOLD_OFF       2'h3
`define RETRY_NONE          3'h0
`define RETRY_FOREVER       3'h7
`define VOUT_MODE_LINEAR    3'h0
`define UNMAPPED_BYTE       8'hFF

// ****************************************
// timing and addressing
// ****************************************
`define MCLK_PERIOD_NS      10
`define OV_DELAY_UNIT_NS    10000
`define OV_DELAY_UNIT_CYC   (`OV_DELAY_UNIT_NS / `MCLK_PERIOD_NS)
`define PMBUS_ADDR          7'h5A

`endif

/* File: cfg_bank_pkg.sv */
// types shared by the configuration command bank
package cfg_bank_pkg;

	typedef struct packed {
		logic [4:0]  exp;
		logic [10:0] mant;
	} linear_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} pmbus_in_t;

	typedef struct packed {
		logic [15:0] monitor_scale;
		logic [15:0] duty_ceiling;
		logic [15:0] switch_rate;
		logic [15:0] input_start;
		logic [15:0] input_stop;
		logic [3:0]  group_id;
		logic [3:0]  unit_count;
		logic [3:0]  position;
		logic [15:0] ov_level;
		logic [4:0]  ov_exp;
	} cfg_t;

	typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_CMD, BUS_WR, BUS_RD} bus_st_t;

	typedef enum logic [2:0] {F_RUN, F_DELAY, F_OFF, F_LATCH} fault_st_t;

	typedef struct packed {
		bus_st_t          st;
		logic [3:0]       bitcnt;
		logic             ack_phase;
		logic [7:0]       shreg;
		logic             rw;
		logic [7:0]       cmd;
		logic [1:0]       byte_idx;
		logic [7:0]       wbuf;
		logic             sda_low;
		logic             scl_q;
		logic             sda_q;
		logic [8:0][15:0] regs;
		logic [4:0]       ov_exp;
		logic             ov;
		logic             resp_wr;
	} bus_state_t;

	typedef struct packed {
		fault_st_t   st;
		logic [15:0] cnt;
		logic [2:0]  retries;
		logic        on;
	} fault_state_t;

endpackage : cfg_bank_pkg

/* File: converter_config_command_bank.sv */
// pmbus command bank for converter configuration words
// Summary of operation
// - 0x2A word holds monitor sense scale factor
// - 0x32 word caps switching duty cycle
// - 0x33 word sets switching frequency, 1 kHz steps
// - 0x35 word is input start voltage
// - 0x36 word is input stop voltage
// - 0x37 bits 11:8 give group identifier
// - 0x37 bits 7:4 give units in group
// - 0x37 bits 3:0 give unit phase position
// - phase offsets relative to shared sync clock
// - 0x39 offset added to every current reading
// - 0x40 word is overvoltage trip level
// - 0x41 bits 7:6 response; 00 ignores fault
// - vout mode 000 linear, exponent bits 4:0
// - 10 disables then retries; 11 holds off
// - retry field 000 none, 111 forever
`timescale 1ns/100ps
`include "cfg_bank_params.svh"

module converter_config_command_bank #(
	parameter logic [6:0] DEV_ADDR    = `PMBUS_ADDR,
	parameter int         UNIT_CYCLES = `OV_DELAY_UNIT_CYC
) (
	// clock and reset
	input  wire logic                    mclk,
	input  wire logic                    reset_n,
	// pmbus pins
	input  wire cfg_bank_pkg::pmbus_in_t bus_in,
	output logic                         sda_out,
	output logic                         sda_oe_n,
	// converter side inputs
	input  wire logic [7:0]              vout_mode,
	input  wire logic [15:0]             vout_sense,
	input  wire cfg_bank_pkg::linear_t   iout_raw,
	input  wire logic                    fault_clear,
	// converter side outputs
	output cfg_bank_pkg::cfg_t           cfg,
	output cfg_bank_pkg::linear_t        iout_reading,
	output logic                         ov_fault,
	output logic                         output_on
);
	cfg_bank_pkg::bus_state_t s_q, s_d;

	logic        scl_rise;
	logic        scl_fall;
	logic        start_seen;
	logic        stop_seen;
	logic        byte_done;
	logic [3:0]  cmd_idx;
	logic [3:0]  rd_idx;
	logic        is_byte_cmd;
	logic        wr_commit;
	logic [15:0] wr_word;
	logic [7:0]  rd_byte;

	// ****************************************
	// command decode
	// ****************************************
	function automatic logic [3:0] index_of(input logic [7:0] code);
		logic [3:0] idx;
		idx = `IDX_NONE;
		case (code)
			`CMD_MONITOR_SCALE:  idx = `IDX_MONITOR_SCALE;
			`CMD_DUTY_CEILING:   idx = `IDX_DUTY_CEILING;
			`CMD_SWITCH_RATE:    idx = `IDX_SWITCH_RATE;
			`CMD_INPUT_START:    idx = `IDX_INPUT_START;
			`CMD_INPUT_STOP:     idx = `IDX_INPUT_STOP;
			`CMD_PHASE_SPREAD:   idx = `IDX_PHASE_SPREAD;
			`CMD_CURRENT_OFFSET: idx = `IDX_CURRENT_OFFSET;
			`CMD_OV_TRIP_LEVEL:  idx = `IDX_OV_TRIP_LEVEL;
			`CMD_OV_TRIP_ACTION: idx = `IDX_OV_TRIP_ACTION;
			default:             idx = `IDX_NONE;
		endcase
		return idx;
	endfunction : index_of

	assign cmd_idx     = index_of(s_q.shreg);
	assign rd_idx      = index_of(s_q.cmd);
	assign is_byte_cmd = (s_q.cmd == `CMD_OV_TRIP_ACTION);

	// ****************************************
	// bus events
	// ****************************************
	assign scl_rise   = bus_in.scl && !s_q.scl_q;
	assign scl_fall   = !bus_in.scl && s_q.scl_q;
	assign start_seen = bus_in.scl && s_q.scl_q && s_q.sda_q && !bus_in.sda;
	assign stop_seen  = bus_in.scl && s_q.scl_q && !s_q.sda_q && bus_in.sda;
	assign byte_done  = scl_fall && !s_q.ack_phase && s_q.bitcnt == 4'h8;

	assign wr_commit = byte_done && s_q.st == cfg_bank_pkg::BUS_WR && rd_idx != `IDX_NONE
		&& ((is_byte_cmd && s_q.byte_idx == 2'h0) || (!is_byte_cmd && s_q.byte_idx == 2'h1));

	always_comb begin
		if (is_byte_cmd) begin
			wr_word = {8'h00, s_q.shreg};
		end else if (s_q.cmd == `CMD_PHASE_SPREAD) begin
			wr_word = {s_q.shreg, s_q.wbuf} & `SPREAD_USED_MASK;
		end else begin
			wr_word = {s_q.shreg, s_q.wbuf};
		end
	end

	// word reads go low byte first; a byte command has no second byte
	always_comb begin
		if (rd_idx == `IDX_NONE) begin
			rd_byte = `UNMAPPED_BYTE;
		end else if (s_q.byte_idx == 2'h0) begin
			rd_byte = s_q.regs[rd_idx][7:0];
		end else if (s_q.byte_idx == 2'h1 && !is_byte_cmd) begin
			rd_byte = s_q.regs[rd_idx][15:8];
		end else begin
			rd_byte = 8'h00;
		end
	end

	// ****************************************
	// state update
	// ****************************************
	always_comb begin
		s_d         = s_q;
		s_d.scl_q   = bus_in.scl;
		s_d.sda_q   = bus_in.sda;
		s_d.resp_wr = 1'b0;
		s_d.ov      = (vout_sense >= s_q.regs[`IDX_OV_TRIP_LEVEL]);
		// direct and vid modes carry no exponent
		s_d.ov_exp  = (vout_mode[7:5] == `VOUT_MODE_LINEAR) ? vout_mode[4:0] : 5'h00;

		if (wr_commit) begin
			s_d.regs[rd_idx] = wr_word;
			s_d.resp_wr      = is_byte_cmd;
		end

		if (start_seen) begin
			s_d.st        = cfg_bank_pkg::BUS_ADDR;
			s_d.bitcnt    = 4'h0;
			s_d.ack_phase = 1'b0;
			s_d.sda_low   = 1'b0;
		end else if (stop_seen) begin
			s_d.st      = cfg_bank_pkg::BUS_IDLE;
			s_d.sda_low = 1'b0;
		end else if (s_q.st != cfg_bank_pkg::BUS_IDLE) begin
			if (scl_rise) begin
				if (s_q.ack_phase) begin
					// master nack ends a read, the line is left free
					if (s_q.st == cfg_bank_pkg::BUS_RD && bus_in.sda) begin
						s_d.st = cfg_bank_pkg::BUS_IDLE;
					end
				end else if (s_q.bitcnt != 4'h8) begin
					s_d.bitcnt = s_q.bitcnt + 4'h1;
					if (s_q.st != cfg_bank_pkg::BUS_RD) begin
						s_d.shreg = {s_q.shreg[6:0], bus_in.sda};
					end
				end
			end else if (byte_done) begin
				s_d.ack_phase = 1'b1;
				case (s_q.st)
					cfg_bank_pkg::BUS_ADDR: begin
						if (s_q.shreg[7:1] == DEV_ADDR) begin
							s_d.sda_low = 1'b1;
							s_d.rw      = s_q.shreg[0];
						end else begin
							s_d.st = cfg_bank_pkg::BUS_IDLE;
						end
					end
					cfg_bank_pkg::BUS_CMD: begin
						s_d.cmd      = s_q.shreg;
						s_d.byte_idx = 2'h0;
						if (cmd_idx != `IDX_NONE) begin
							s_d.sda_low = 1'b1;
						end else begin
							s_d.st = cfg_bank_pkg::BUS_IDLE;
						end
					end
					cfg_bank_pkg::BUS_WR: begin
						if (s_q.byte_idx == 2'h0) begin
							s_d.wbuf = s_q.shreg;
						end
						// bytes past the command's length are refused
						if ((is_byte_cmd && s_q.byte_idx != 2'h0) || s_q.byte_idx > 2'h1) begin
							s_d.st = cfg_bank_pkg::BUS_IDLE;
						end else begin
							s_d.sda_low  = 1'b1;
							s_d.byte_idx = s_q.byte_idx + 2'h1;
						end
					end
					default: begin
						s_d.sda_low = 1'b0;
					end
				endcase
			end else if (scl_fall && s_q.ack_phase) begin
				s_d.ack_phase = 1'b0;
				s_d.bitcnt    = 4'h0;
				s_d.sda_low   = 1'b0;
				case (s_q.st)
					cfg_bank_pkg::BUS_ADDR: begin
						if (s_q.rw) begin
							s_d.st       = cfg_bank_pkg::BUS_RD;
							s_d.byte_idx = 2'h0;
							s_d.shreg    = s_q.regs[rd_idx == `IDX_NONE ? 4'h0 : rd_idx][7:0];
							if (rd_idx == `IDX_NONE) begin
								s_d.shreg = `UNMAPPED_BYTE;
							end
							s_d.sda_low = !s_d.shreg[7];
						end else begin
							s_d.st = cfg_bank_pkg::BUS_CMD;
						end
					end
					cfg_bank_pkg::BUS_CMD: begin
						s_d.st = cfg_bank_pkg::BUS_WR;
					end
					cfg_bank_pkg::BUS_RD: begin
						s_d.byte_idx = (s_q.byte_idx == 2'h3) ? 2'h3 : s_q.byte_idx + 2'h1;
						s_d.shreg    = (s_q.byte_idx == 2'h0 && !is_byte_cmd && rd_idx != `IDX_NONE)
							? s_q.regs[rd_idx][15:8] : 8'h00;
						s_d.sda_low  = !s_d.shreg[7];
					end
					default: begin
						s_d.st = s_q.st;
					end
				endcase
			end else if (scl_fall && s_q.st == cfg_bank_pkg::BUS_RD && s_q.bitcnt != 4'h8) begin
				s_d.shreg   = {s_q.shreg[6:0], 1'b0};
				s_d.sda_low = !s_q.shreg[6];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_q <= '{st: cfg_bank_pkg::BUS_IDLE, bitcnt: 4'h0, ack_phase: 1'b0, shreg: 8'h00,
				rw: 1'b0, cmd: 8'h00, byte_idx: 2'h0, wbuf: 8'h00, sda_low: 1'b0,
				scl_q: 1'b1, sda_q: 1'b1, regs: {`NUM_REGS{`CFG_RESET_WORD}},
				ov_exp: 5'h00, ov: 1'b0, resp_wr: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs and children
	// ****************************************
	// open drain: only ever pulls low
	assign sda_out  = 1'b0;
	assign sda_oe_n = !s_q.sda_low;
	assign ov_fault = s_q.ov;

	always_comb begin
		cfg.monitor_scale = s_q.regs[`IDX_MONITOR_SCALE];
		cfg.duty_ceiling  = s_q.regs[`IDX_DUTY_CEILING];
		cfg.switch_rate   = s_q.regs[`IDX_SWITCH_RATE];
		cfg.input_start   = s_q.regs[`IDX_INPUT_START];
		cfg.input_stop    = s_q.regs[`IDX_INPUT_STOP];
		cfg.group_id      = s_q.regs[`IDX_PHASE_SPREAD][11:8];
		cfg.unit_count    = s_q.regs[`IDX_PHASE_SPREAD][7:4];
		// position counts from the shared sync edge
		cfg.position      = s_q.regs[`IDX_PHASE_SPREAD][3:0];
		cfg.ov_level      = s_q.regs[`IDX_OV_TRIP_LEVEL];
		cfg.ov_exp        = s_q.ov_exp;
	end

	current_offset u_current_offset (
		.mclk    (mclk),
		.reset_n (reset_n),
		.raw     (iout_raw),
		.offset  (cfg_bank_pkg::linear_t'(s_q.regs[`IDX_CURRENT_OFFSET])),
		.reading (iout_reading)
	);

	ov_response #(
		.UNIT_CYCLES (UNIT_CYCLES)
	) u_ov_response (
		.mclk        (mclk),
		.reset_n     (reset_n),
		.fault       (s_q.ov),
		.fault_clear (fault_clear),
		.resp_wr     (s_q.resp_wr),
		.resp        (s_q.regs[`IDX_OV_TRIP_ACTION][7:0]),
		.output_on   (output_on)
	);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	scale_write_a: assert property (
		(wr_commit && s_q.cmd == `CMD_MONITOR_SCALE) |=> cfg.monitor_scale == $past(wr_word))
		else $error("monitor scale not updated by word write");
	duty_write_a: assert property (
		(wr_commit && s_q.cmd == `CMD_DUTY_CEILING) ##1 !wr_commit [*2] |-> $stable(cfg.duty_ceiling))
		else $error("duty ceiling changed without a write");
	spread_fields_a: assert property (
		(wr_commit && s_q.cmd == `CMD_PHASE_SPREAD)
		|=> {cfg.group_id, cfg.unit_count, cfg.position} == $past({s_q.shreg[3:0], s_q.wbuf}))
		else $error("interleave fields do not match written word");
	spread_upper_a: assert property (
		s_q.regs[`IDX_PHASE_SPREAD][15:12] == 4'h0)
		else $error("interleave upper bits not zero");
	// a reset edge leaves the compare flag one cycle stale
	ov_compare_a: assert property (
		$past(reset_n) |-> ov_fault == $past(vout_sense >= s_q.regs[`IDX_OV_TRIP_LEVEL]))
		else $error("overvoltage flag does not track limit");
	vout_exp_a: assert property (
		$past(vout_mode[7:5]) == `VOUT_MODE_LINEAR |-> cfg.ov_exp == $past(vout_mode[4:0]))
		else $error("linear exponent not taken from mode");
	unmapped_nack_a: assert property (
		(byte_done && s_q.st == cfg_bank_pkg::BUS_CMD && cmd_idx == `IDX_NONE) |=> sda_oe_n)
		else $error("unmapped command acknowledged");
	byte_resp_wr_a: assert property (
		(wr_commit && is_byte_cmd) |=> s_q.resp_wr ##1 !s_q.resp_wr)
		else $error("response write pulse malformed");
	// each write lands in its register one cycle after the commit
	rate_write_a: assert property (
		(wr_commit && s_q.cmd == `CMD_SWITCH_RATE) |=> cfg.switch_rate == $past(wr_word))
		else $error("switch rate not updated by word write");
	start_write_a: assert property (
		(wr_commit && s_q.cmd == `CMD_INPUT_START) |=> cfg.input_start == $past(wr_word))
		else $error("input start level not updated by word write");
	stop_write_a: assert property (
		(wr_commit && s_q.cmd == `CMD_INPUT_STOP) |=> cfg.input_stop == $past(wr_word))
		else $error("input stop level not updated by word write");
	offset_write_a: assert property (
		(wr_commit && s_q.cmd == `CMD_CURRENT_OFFSET) |=> s_q.regs[`IDX_CURRENT_OFFSET] == $past(wr_word))
		else $error("current offset not updated by word write");
	iout_offset_a: assert property (
		($past(reset_n) && $past(s_q.regs[`IDX_CURRENT_OFFSET]) == 16'h0000) |-> iout_reading == $past(iout_raw))
		else $error("zero offset changed the current reading");
	level_write_a: assert property (
		(wr_commit && s_q.cmd == `CMD_OV_TRIP_LEVEL) |=> cfg.ov_level == $past(wr_word))
		else $error("trip level not updated by word write");
	action_write_a: assert property (
		(wr_commit && is_byte_cmd) |=> s_q.regs[`IDX_OV_TRIP_ACTION] == {8'h00, $past(s_q.shreg)})
		else $error("response byte not stored");

	word_write_c: cover property (wr_commit && !is_byte_cmd);
	read_start_c: cover property (scl_fall && s_q.ack_phase && s_q.st == cfg_bank_pkg::BUS_ADDR && s_q.rw);
	ov_shutdown_c: cover property (ov_fault ##[1:4] !output_on);
	byte_write_c: cover property (wr_commit && is_byte_cmd);

endmodule : converter_config_command_bank

/* File: current_offset.sv */
// applies the calibration offset to every output-current reading
`timescale 1ns/100ps

module current_offset (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  reset_n,
	// raw reading and offset, both linear words
	input  wire cfg_bank_pkg::linear_t raw,
	input  wire cfg_bank_pkg::linear_t offset,
	// corrected reading in the raw exponent
	output cfg_bank_pkg::linear_t      reading
);
	cfg_bank_pkg::linear_t s_q, s_d;
	logic signed [5:0]  diff;
	logic signed [31:0] aligned;
	logic signed [31:0] sum;

	always_comb begin
		diff    = $signed({offset.exp[4], offset.exp}) - $signed({raw.exp[4], raw.exp});
		aligned = (diff >= 0) ? (32'($signed(offset.mant)) <<< diff) : (32'($signed(offset.mant)) >>> (-diff));
		sum     = 32'($signed(raw.mant)) + aligned;
		s_d.exp = raw.exp;
		// saturate rather than wrap, a wrapped reading would flip sign
		if (sum > 32'sd1023) begin
			s_d.mant = 11'h3FF;
		end else if (sum < -32'sd1024) begin
			s_d.mant = 11'h400;
		end else begin
			s_d.mant = sum[10:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign reading = s_q;

endmodule : current_offset

/* File: ov_response.sv */
// output overvoltage fault response sequencer
`timescale 1ns/100ps
`include "cfg_bank_params.svh"

module ov_response #(
	parameter int UNIT_CYCLES = `OV_DELAY_UNIT_CYC
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// fault and settings
	input  wire logic       fault,
	input  wire logic       fault_clear,
	input  wire logic       resp_wr,
	input  wire logic [7:0] resp,
	// output control
	output logic            output_on
);
	cfg_bank_pkg::fault_state_t s_q, s_d;
	logic [15:0] delay_load;
	logic [1:0]  mode;

	assign mode       = resp[7:6];
	assign delay_load = 16'(32'(resp[2:0]) * UNIT_CYCLES);
	assign output_on  = s_q.on;

	always_comb begin
		s_d = s_q;
		case (mode)
			`RESP_IGNORE: begin
				s_d.st = cfg_bank_pkg::F_RUN;
				s_d.on = 1'b1;
			end
			`RESP_HOLD_OFF: begin
				s_d.st = cfg_bank_pkg::F_RUN;
				s_d.on = !fault;
			end
			default: begin
				case (s_q.st)
					cfg_bank_pkg::F_RUN: begin
						s_d.on = 1'b1;
						if (fault && mode == `RESP_DELAY_RETRY && delay_load != 16'h0000) begin
							s_d.st  = cfg_bank_pkg::F_DELAY;
							s_d.cnt = delay_load - 16'h0001;
						end else if (fault) begin
							s_d.on  = 1'b0;
							s_d.st  = (s_q.retries == `RETRY_NONE) ? cfg_bank_pkg::F_LATCH : cfg_bank_pkg::F_OFF;
							s_d.cnt = delay_load;
						end
					end
					cfg_bank_pkg::F_DELAY: begin
						if (!fault) begin
							s_d.st = cfg_bank_pkg::F_RUN;
						end else if (s_q.cnt == 16'h0000) begin
							s_d.on  = 1'b0;
							s_d.st  = (s_q.retries == `RETRY_NONE) ? cfg_bank_pkg::F_LATCH : cfg_bank_pkg::F_OFF;
							s_d.cnt = delay_load;
						end else begin
							s_d.cnt = s_q.cnt - 16'h0001;
						end
					end
					cfg_bank_pkg::F_OFF: begin
						s_d.on = 1'b0;
						if (s_q.cnt == 16'h0000) begin
							s_d.on = 1'b1;
							s_d.st = cfg_bank_pkg::F_RUN;
							if (s_q.retries != `RETRY_FOREVER) begin
								s_d.retries = s_q.retries - 3'h1;
							end
						end else begin
							s_d.cnt = s_q.cnt - 16'h0001;
						end
					end
					default: begin
						s_d.on = 1'b0;
					end
				endcase
			end
		endcase
		// a new setting or a clear restarts the retry budget
		if (fault_clear || resp_wr) begin
			s_d.retries = resp[5:3];
		end
		if (fault_clear) begin
			s_d.st = cfg_bank_pkg::F_RUN;
			s_d.on = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_q <= '{st: cfg_bank_pkg::F_RUN, cnt: 16'h0000, retries: 3'h0, on: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	ignore_keeps_on_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(mode == `RESP_IGNORE && $past(mode) == `RESP_IGNORE) |-> output_on)
		else $error("output dropped while fault is ignored");
	delay_keeps_on_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(mode == `RESP_DELAY_RETRY && s_q.st == cfg_bank_pkg::F_RUN && fault && resp[2:0] != 3'h0
		&& !fault_clear) |=> output_on [*2])
		else $error("output dropped before fault delay ran out");
	disable_now_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(mode == `RESP_DISABLE_RETRY && s_q.st == cfg_bank_pkg::F_RUN && fault && !fault_clear)
		|=> !output_on)
		else $error("output not disabled on fault");
	hold_follows_fault_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(mode == `RESP_HOLD_OFF && $past(mode) == `RESP_HOLD_OFF && !$past(fault_clear))
		|-> output_on == !$past(fault))
		else $error("hold-off output does not follow the fault");
	no_retry_latch_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(s_q.st == cfg_bank_pkg::F_LATCH && mode[1] != mode[0] && !fault_clear) |=> !output_on)
		else $error("output restarted with no retries left");
	retry_seen_c: cover property (@(posedge mclk) disable iff (!reset_n)
		s_q.st == cfg_bank_pkg::F_OFF ##1 s_q.st == cfg_bank_pkg::F_RUN);

endmodule : ov_response

/* File: pmbus_host_model.sv */
// pmbus host model driving the bank's two-wire bus
`timescale 1ns/100ps

module pmbus_host_model #(
	parameter logic [6:0] ADDR = 7'h00
) (
	// clock and bus lines
	input  wire logic   mclk,
	input  wire logic   sda,
	output logic        scl,
	output logic        sda_low,
	// results of the last transfer
	output logic        rd_v,
	output logic [15:0] rd_d,
	output logic        nak
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		rd_v = 1'b0;
		rd_d = 16'h0000;
		nak = 1'b0;
	end
	task automatic hc(input int n);
		repeat (n) @(negedge mclk);
	endtask : hc
	// data moves only while the clock is low
	task automatic bit_x(input logic b, output logic r);
		hc(2);
		sda_low = ~b;
		hc(2);
		scl = 1'b1;
		hc(4);
		r = sda;
		scl = 1'b0;
	endtask : bit_x
	task automatic wb(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(b[i], r);
		bit_x(1'b1, r);
		nak |= r;
	endtask : wb
	task automatic rb(output logic [7:0] b, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
		bit_x(last, r);
	endtask : rb
	// also serves as repeated start
	task automatic start;
		sda_low = 1'b0;
		hc(2);
		scl = 1'b1;
		hc(4);
		sda_low = 1'b1;
		hc(4);
		scl = 1'b0;
	endtask : start
	task automatic stop;
		hc(2);
		sda_low = 1'b1;
		hc(2);
		scl = 1'b1;
		hc(4);
		sda_low = 1'b0;
		hc(4);
	endtask : stop
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, input int n);
		nak = 1'b0;
		start;
		wb({a, 1'b0});
		wb(c);
		wb(d[7:0]);
		if (n > 1) wb(d[15:8]);
		stop;
	endtask : wr
	// low byte first, last byte refused by the host
	task automatic rd(input logic [7:0] c, input int n);
		logic [7:0] lo, hi;
		hi = 8'h00;
		nak = 1'b0;
		start;
		wb({ADDR, 1'b0});
		wb(c);
		start;
		wb({ADDR, 1'b1});
		rb(lo, n == 1);
		if (n > 1) rb(hi, 1'b1);
		stop;
		rd_d = {hi, lo};
		rd_v = 1'b1;
		hc(1);
		rd_v = 1'b0;
	endtask : rd
endmodule : pmbus_host_model

/* File: tb_converter_config_command_bank.sv */
// self-checking bench for the converter configuration command bank
`timescale 1ns/100ps
`include "cfg_bank_params.svh"

module tb_converter_config_command_bank;
	// ********
	// wiring
	// ********
	logic                    mclk, reset_n, scl, sda_low, sda_out, sda_oe_n, pv;
	logic                    fault_clear, ov_fault, output_on, rd_v, nak;
	logic [7:0]              vout_mode;
	logic [15:0]             vout_sense, rd_d, pval, e, g, d, x;
	logic [7:0]              codes [9];
	logic [15:0]             cw [9];
	cfg_bank_pkg::pmbus_in_t bus_in;
	cfg_bank_pkg::linear_t   iout_raw, iout_reading;
	cfg_bank_pkg::cfg_t      cfg;
	logic [15:0]             q [$];
	string                   nq [$];
	string                   nm;
	int                      n_errors, checks, cyc;
	// released line floats high through the pull-up
	assign bus_in = {scl, ~sda_low & (sda_oe_n | sda_out)};
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	converter_config_command_bank #(.UNIT_CYCLES(4)) uut (.mclk(mclk), .reset_n(reset_n), .bus_in(bus_in),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .vout_mode(vout_mode), .vout_sense(vout_sense),
		.iout_raw(iout_raw), .fault_clear(fault_clear), .cfg(cfg), .iout_reading(iout_reading),
		.ov_fault(ov_fault), .output_on(output_on));
	pmbus_host_model #(.ADDR(`PMBUS_ADDR)) host (.mclk(mclk), .sda(bus_in.sda), .scl(scl),
		.sda_low(sda_low), .rd_v(rd_v), .rd_d(rd_d), .nak(nak));
	// ********
	// tasks
	// ********
	task automatic give_verdict;
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic wait_n(input int n);
		repeat (n) @(negedge mclk);
	endtask : wait_n
	task automatic note(input string n, input logic [15:0] v);
		nq.push_back(n);
		q.push_back(v);
	endtask : note
	task automatic probe(input string n, input logic [15:0] v, input logic [15:0] s);
		note(n, v);
		pval = s;
		pv = 1'b1;
		wait_n(1);
		pv = 1'b0;
		wait_n(1);
	endtask : probe
	task automatic chk_rd(input string n, input logic [7:0] c, input logic [15:0] v, input int b);
		note(n, v);
		host.rd(c, b);
	endtask : chk_rd
	task automatic ov_case(input logic [7:0] r, input int dly, input logic on_f, input logic on_c);
		vout_sense = 16'h0000;
		host.wr(`PMBUS_ADDR, `CMD_OV_TRIP_ACTION, {8'h00, r}, 1);
		wait_n(4);
		vout_sense = 16'h0900;
		wait_n(dly);
		probe("ov_fault", 16'h0001, {15'h0000, ov_fault});
		probe("on_fault", {15'h0000, on_f}, {15'h0000, output_on});
		vout_sense = 16'h0000;
		wait_n(20);
		probe("on_after", {15'h0000, on_c}, {15'h0000, output_on});
	endtask : ov_case
	// ********
	// result watcher and hang limit
	// ********
	always @(posedge mclk) begin
		cyc++;
		if (rd_v | pv) begin
			checks++;
			nm = nq.pop_front();
			e = q.pop_front();
			g = pv ? pval : rd_d;
			if (e !== g) begin
				n_errors++;
				$display("mismatch %s expected %h seen %h", nm, e, g);
			end
		end
		if (cyc == 60000) begin
			n_errors++;
			give_verdict;
		end
	end
	// ********
	// stimulus
	// ********
	initial begin
		void'($urandom(32'hd90e_0ae9));
		codes = '{`CMD_MONITOR_SCALE, `CMD_DUTY_CEILING, `CMD_SWITCH_RATE, `CMD_INPUT_START,
			`CMD_INPUT_STOP, `CMD_PHASE_SPREAD, `CMD_CURRENT_OFFSET, `CMD_OV_TRIP_LEVEL, `CMD_OV_TRIP_ACTION};
		reset_n = 1'b0;
		pv = 1'b0;
		fault_clear = 1'b0;
		vout_mode = 8'h00;
		vout_sense = 16'h0000;
		iout_raw = 16'h0000;
		wait_n(16);
		reset_n = 1'b1;
		wait_n(4);
		for (int i = 0; i < 9; i++) chk_rd("reset", codes[i], 16'h0000, i == 8 ? 1 : 2);
		for (int i = 0; i < 9; i++) begin
			d = 16'($urandom);
			host.wr(`PMBUS_ADDR, codes[i], d, i == 8 ? 1 : 2);
			probe("ack", 16'h0000, {15'h0000, nak});
			x = i == 5 ? d & `SPREAD_USED_MASK : (i == 8 ? d & 16'h00FF : d);
			chk_rd("readback", codes[i], x, i == 8 ? 1 : 2);
			cw = '{cfg.monitor_scale, cfg.duty_ceiling, cfg.switch_rate, cfg.input_start, cfg.input_stop,
				{4'h0, cfg.group_id, cfg.unit_count, cfg.position}, 16'h0000, cfg.ov_level, 16'h0000};
			if (i != 6 && i != 8) probe("cfg_word", x, cw[i]);
		end
		host.wr(`PMBUS_ADDR, `CMD_PHASE_SPREAD, 16'hFA53, 2);
		probe("group_id", 16'h000A, {12'h000, cfg.group_id});
		probe("unit_count", 16'h0005, {12'h000, cfg.unit_count});
		probe("position", 16'h0003, {12'h000, cfg.position});
		host.wr(`PMBUS_ADDR, `CMD_PHASE_SPREAD, 16'h0A50, 2);
		probe("sync_position", 16'h0000, {12'h000, cfg.position});
		host.wr(`PMBUS_ADDR, `CMD_SWITCH_RATE, 16'h0064, 2);
		host.wr(7'h5B, `CMD_SWITCH_RATE, 16'h0190, 2);
		probe("foreign_nak", 16'h0001, {15'h0000, nak});
		probe("switch_rate", 16'h0064, cfg.switch_rate);
		host.wr(`PMBUS_ADDR, 8'h34, 16'h1111, 2);
		probe("unmapped_nak", 16'h0001, {15'h0000, nak});
		host.wr(`PMBUS_ADDR, `CMD_CURRENT_OFFSET, 16'h0005, 2);
		iout_raw = 16'h000A;
		wait_n(3);
		probe("iout", 16'h000F, iout_reading);
		vout_mode = 8'h1D;
		host.wr(`PMBUS_ADDR, `CMD_OV_TRIP_LEVEL, 16'h0800, 2);
		probe("ov_exp", 16'h001D, {11'h000, cfg.ov_exp});
		ov_case(8'h00, 4, 1'b1, 1'b1);
		ov_case(8'hC0, 4, 1'b0, 1'b1);
		ov_case(8'h42, 3, 1'b1, 1'b1);
		ov_case(8'h80, 4, 1'b0, 1'b0);
		fault_clear = 1'b1;
		wait_n(1);
		fault_clear = 1'b0;
		wait_n(4);
		probe("restart", 16'h0001, {15'h0000, output_on});
		ov_case(8'h41, 12, 1'b0, 1'b0);
		wait_n(4);
		give_verdict;
	end
endmodule : tb_converter_config_command_bank
